// ---- hdl/cfo_chan.sv ----
// one differential output channel: registered legs and driver enable
// assumes run and park_tri are computed on clk_sys and ref_lvl is synchronised
`timescale 1ns/100ps
`default_nettype none
module cfo_chan (
	input  wire logic clk_sys,
	input  wire logic nrst,
	input  wire logic ce,
	input  wire logic run,
	input  wire logic park_tri,
	input  wire logic ref_lvl,
	output logic      leg_p,
	output logic      leg_n,
	output logic      leg_oe
);
	// ****************************************
	// output legs
	// ****************************************
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			leg_p  <= 1'b0;
			leg_n  <= 1'b0;
			leg_oe <= 1'b1;
		end else if (ce) begin
			leg_p  <= run & ref_lvl;
			leg_n  <= run & ~ref_lvl;
			leg_oe <= run | ~park_tri;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	chan_stop_low_a: assert property ((ce && !run) |=> (!leg_p && !leg_n))
		else $error("stopped channel leg high");
	chan_park_tri_a: assert property ((ce && !run && park_tri) |=> !leg_oe)
		else $error("parked channel still driven");
	chan_follow_a: assert property ((ce && run) |=> (leg_oe && (leg_p == $past(ref_lvl))
		&& (leg_n != leg_p)))
		else $error("running channel does not follow reference");
endmodule
`default_nettype wire

// ---- hdl/cfo_pkg.sv ----
// constants shared by the clock fanout output control block
// assumes a single system clock domain; all pins arrive unsynchronised
package cfo_pkg;

	// ****************************************
	// register indices (7-bit command address)
	// ****************************************
	localparam logic [6:0] IDX_RSVD1  = 7'h00;
	localparam logic [6:0] IDX_EN_A   = 7'h01;
	localparam logic [6:0] IDX_EN_B   = 7'h02;
	localparam logic [6:0] IDX_PIN_RB = 7'h03;
	localparam logic [6:0] IDX_RSVD2  = 7'h04;
	localparam logic [6:0] IDX_REV    = 7'h05;
	localparam logic [6:0] IDX_PART   = 7'h06;
	localparam logic [6:0] IDX_RDCNT  = 7'h07;
	localparam logic [6:0] IDX_OUTPUT_SETTING = 7'h08;
	localparam logic [6:0] IDX_SLEW   = 7'h4C;

	// ****************************************
	// reset values and field layout
	// ****************************************
	localparam logic [3:0] RST_RSVD1_HI  = 4'h4;
	localparam logic [3:0] RST_RSVD1_LO  = 4'h7;
	localparam logic [7:0] RST_EN_A      = 8'hFF;
	localparam logic [7:0] RST_EN_B      = 8'h0F;
	localparam logic [7:0] RST_RDCNT     = 8'h08;
	localparam logic [7:0] RST_OUTPUT_SETTING    = 8'h00;
	localparam logic [7:0] RST_SLEW      = 8'h66;
	localparam logic [7:0] OUTPUT_SETTING_WMASK  = 8'h3F;
	localparam int         OUTPUT_SETTING_TERM   = 5;
	localparam int         OUTPUT_SETTING_PARK   = 4;
	localparam int         CMD_BYTE_BIT  = 7;
	localparam int         EN_A_CH0      = 1;
	localparam int         EN_A_CH1      = 2;
	localparam int         EN_A_CH2      = 4;
	localparam int         EN_A_CH3      = 5;
	localparam int         EN_A_CH4      = 6;
	localparam int         EN_A_CH5      = 7;
	localparam int         EN_B_CH6      = 0;
	localparam int         EN_B_CH7      = 2;

	// ****************************************
	// slave address selection
	// ****************************************
	localparam logic [1:0] LVL_L   = 2'h0;
	localparam logic [1:0] LVL_M   = 2'h1;
	localparam logic [1:0] LVL_H   = 2'h2;
	localparam logic [7:0] ADDR_LL = 8'hD8;
	localparam logic [7:0] ADDR_LM = 8'hDA;
	localparam logic [7:0] ADDR_LH = 8'hDE;
	localparam logic [7:0] ADDR_ML = 8'hC2;
	localparam logic [7:0] ADDR_MM = 8'hC4;
	localparam logic [7:0] ADDR_MH = 8'hC6;
	localparam logic [7:0] ADDR_HL = 8'hCA;
	localparam logic [7:0] ADDR_HM = 8'hCC;
	localparam logic [7:0] ADDR_HH = 8'hCE;

	// ****************************************
	// counts
	// ****************************************
	localparam logic [1:0] PD_REF_EDGES = 2'h3;
	localparam int         NUM_CH       = 8;
	localparam int         SYNC_W       = 16;

	typedef enum logic [2:0] {
		SM_IDLE, SM_ADDR, SM_CMD, SM_WCNT, SM_WDATA, SM_RCNT, SM_RDATA
	} cfo_sm_e;

endpackage

// ---- hdl/cfo_top.sv ----
// output enable, power-good and slave register control of the fanout buffer
// assumes all pins are asynchronous to clk_sys; the reference clock is only
// sampled, so outputs are a sampled copy at clk_sys resolution
`timescale 1ns/100ps
`default_nettype none
module cfo_top #(
	parameter logic [7:0] REV_VENDOR_ID = 8'h5C, // arbitrary value
	parameter logic [7:0] PART_ID       = 8'h3B  // arbitrary value
) (
	input  wire logic       clk_sys,
	input  wire logic       nrst,
	input  wire logic       ce,
	input  wire logic       input_reference_clock,
	input  wire logic       power_good_powerdown_pin,
	input  wire logic [7:0] hw_output_enable_pin_n,
	input  wire logic [1:0] addr_select_pin_0,
	input  wire logic [1:0] addr_select_pin_1,
	input  wire logic       smb_clk_in,
	input  wire logic       smb_data_in,
	output logic            smb_data_out,
	output logic            smb_data_oe,
	output logic [7:0]      buffered_clock_outputs_p,
	output logic [7:0]      buffered_clock_outputs_n,
	output logic [7:0]      buffered_clock_outputs_oe,
	output logic            termination_select_bit,
	output logic [3:0]      slew_trim_lo,
	output logic [3:0]      slew_trim_hi,
	output logic            power_good_state
);
	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [cfo_pkg::SYNC_W-1:0] sync1_reg;
	logic [cfo_pkg::SYNC_W-1:0] sync2_reg;
	logic [3:0]                 prev_reg;
	wire  [cfo_pkg::SYNC_W-1:0] pins_raw = {addr_select_pin_1, addr_select_pin_0,
		hw_output_enable_pin_n, smb_data_in, smb_clk_in,
		power_good_powerdown_pin, input_reference_clock};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= 4'h0;
		end else if (ce) begin
			sync1_reg <= pins_raw;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg[3:0];
		end
	end

	wire       ref_s   = sync2_reg[0];
	wire       pg_s    = sync2_reg[1];
	wire       scl_s   = sync2_reg[2];
	wire       sda_s   = sync2_reg[3];
	wire [7:0] oe_n_s  = sync2_reg[11:4];
	wire [3:0] sel_s   = sync2_reg[15:12];
	wire       ref_rise = ref_s & ~prev_reg[0];
	wire       pg_rise  = pg_s & ~prev_reg[1];
	wire       scl_rise = scl_s & ~prev_reg[2];
	wire       scl_fall = ~scl_s & prev_reg[2];
	wire       start_det = scl_s & prev_reg[2] & prev_reg[3] & ~sda_s;
	wire       stop_det  = scl_s & prev_reg[2] & ~prev_reg[3] & sda_s;

	// ****************************************
	// power-good and power-down state
	// ****************************************
	logic       pgood_reg;
	logic       pd_n_reg;
	logic [1:0] pd_cnt_reg;
	logic [3:0] sel_reg;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pgood_reg  <= 1'b0;
			pd_n_reg   <= 1'b0;
			pd_cnt_reg <= 2'h0;
			sel_reg    <= 4'h0;
		end else if (ce) begin
			if (pg_rise && !pgood_reg) begin
				pgood_reg <= 1'b1;
				sel_reg   <= sel_s;
			end
			if (pgood_reg && pg_s) begin
				pd_n_reg   <= 1'b1;
				pd_cnt_reg <= 2'h0;
			end else if (pgood_reg && pd_n_reg && ref_rise) begin
				// stop only after the reference has still run a few edges
				if (pd_cnt_reg == cfo_pkg::PD_REF_EDGES - 2'h1)
					pd_n_reg <= 1'b0;
				pd_cnt_reg <= pd_cnt_reg + 2'h1;
			end
		end
	end

	// select pins decode to the slave address
	wire [3:0] sl = sel_reg;
	wire [7:0] addr_w =
		(sl == {cfo_pkg::LVL_L, cfo_pkg::LVL_L}) ? cfo_pkg::ADDR_LL :
		(sl == {cfo_pkg::LVL_L, cfo_pkg::LVL_M}) ? cfo_pkg::ADDR_LM :
		(sl == {cfo_pkg::LVL_L, cfo_pkg::LVL_H}) ? cfo_pkg::ADDR_LH :
		(sl == {cfo_pkg::LVL_M, cfo_pkg::LVL_L}) ? cfo_pkg::ADDR_ML :
		(sl == {cfo_pkg::LVL_M, cfo_pkg::LVL_M}) ? cfo_pkg::ADDR_MM :
		(sl == {cfo_pkg::LVL_M, cfo_pkg::LVL_H}) ? cfo_pkg::ADDR_MH :
		(sl == {cfo_pkg::LVL_H, cfo_pkg::LVL_L}) ? cfo_pkg::ADDR_HL :
		(sl == {cfo_pkg::LVL_H, cfo_pkg::LVL_M}) ? cfo_pkg::ADDR_HM :
		cfo_pkg::ADDR_HH;
	wire bus_on = pgood_reg & pg_s;

	// ****************************************
	// registers
	// ****************************************
	logic [3:0] rsvd1_reg;
	logic [7:0] en_a_reg;
	logic [7:0] en_b_reg;
	logic [7:0] rdcnt_reg;
	logic [7:0] output_setting_reg;
	logic [7:0] slew_reg;
	logic [6:0] ptr_reg;
	logic [7:0] sh_reg;
	logic       wr_go;

	wire [6:0] ptr_inc = ptr_reg + 7'h01;

	function automatic logic [7:0] reg_read(input logic [6:0] idx);
		logic [7:0] v;
		v = 8'h00;
		unique case (idx)
			cfo_pkg::IDX_RSVD1:  v = {cfo_pkg::RST_RSVD1_HI, rsvd1_reg};
			cfo_pkg::IDX_EN_A:   v = en_a_reg;
			cfo_pkg::IDX_EN_B:   v = en_b_reg;
			cfo_pkg::IDX_PIN_RB: v = oe_n_s;
			cfo_pkg::IDX_REV:    v = REV_VENDOR_ID;
			cfo_pkg::IDX_PART:   v = PART_ID;
			cfo_pkg::IDX_RDCNT:  v = rdcnt_reg;
			cfo_pkg::IDX_OUTPUT_SETTING: v = output_setting_reg;
			cfo_pkg::IDX_SLEW:   v = slew_reg;
			default:             v = 8'h00;
		endcase
		return v;
	endfunction

	logic [7:0] rd_cur;
	logic [7:0] rd_inc;

	// a process, not an assign, so a register change alone refreshes the read data
	always_comb begin
		rd_cur = reg_read(ptr_reg);
		rd_inc = reg_read(ptr_inc);
	end
	wire [7:0] cnt_byte = {3'h0, rdcnt_reg[4:0]};
	wire       wr_rsvd1  = wr_go && (ptr_reg == cfo_pkg::IDX_RSVD1);
	wire       wr_en_a   = wr_go && (ptr_reg == cfo_pkg::IDX_EN_A);
	wire       wr_en_b   = wr_go && (ptr_reg == cfo_pkg::IDX_EN_B);
	wire       wr_rdcnt  = wr_go && (ptr_reg == cfo_pkg::IDX_RDCNT);
	wire       wr_output_setting = wr_go && (ptr_reg == cfo_pkg::IDX_OUTPUT_SETTING);
	wire       wr_slew   = wr_go && (ptr_reg == cfo_pkg::IDX_SLEW);

	// writes only happen from the slave engine, which is idle while bus_on is low
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rsvd1_reg  <= cfo_pkg::RST_RSVD1_LO;
			en_a_reg   <= cfo_pkg::RST_EN_A;
			en_b_reg   <= cfo_pkg::RST_EN_B;
			rdcnt_reg  <= cfo_pkg::RST_RDCNT;
			output_setting_reg <= cfo_pkg::RST_OUTPUT_SETTING;
			slew_reg   <= cfo_pkg::RST_SLEW;
		end else if (ce) begin
			if (wr_rsvd1)  rsvd1_reg  <= sh_reg[3:0];
			if (wr_en_a)   en_a_reg   <= sh_reg;
			if (wr_en_b)   en_b_reg   <= sh_reg;
			if (wr_rdcnt)  rdcnt_reg  <= sh_reg;
			if (wr_output_setting) output_setting_reg <= sh_reg & cfo_pkg::OUTPUT_SETTING_WMASK;
			if (wr_slew)   slew_reg   <= sh_reg;
		end
	end

	// ****************************************
	// slave engine
	// ****************************************
	cfo_pkg::cfo_sm_e st_reg, st_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] sh_next;
	logic [6:0] ptr_next;
	logic       drv_reg, drv_next;
	logic       blk_reg, blk_next;
	logic       rd_reg, rd_next;
	logic       sda_out_reg;

	wire rx_st = (st_reg == cfo_pkg::SM_ADDR) || (st_reg == cfo_pkg::SM_CMD) ||
		(st_reg == cfo_pkg::SM_WCNT) || (st_reg == cfo_pkg::SM_WDATA);
	wire tx_st = (st_reg == cfo_pkg::SM_RCNT) || (st_reg == cfo_pkg::SM_RDATA);
	wire addr_hit = (sh_reg[7:1] == addr_w[7:1]);
	wire [7:0] first_tx = blk_reg ? cnt_byte : rd_cur;

	always_comb begin
		st_next = st_reg;
		bit_next = bit_reg;
		sh_next = sh_reg;
		ptr_next = ptr_reg;
		drv_next = drv_reg;
		blk_next = blk_reg;
		rd_next = rd_reg;
		wr_go = 1'b0;
		if (!bus_on) begin
			st_next = cfo_pkg::SM_IDLE;
			bit_next = 4'h0;
			drv_next = 1'b0;
		end else if (start_det) begin
			st_next = cfo_pkg::SM_ADDR;
			bit_next = 4'h0;
			drv_next = 1'b0;
		end else if (stop_det) begin
			st_next = cfo_pkg::SM_IDLE;
			drv_next = 1'b0;
		end else if (scl_rise) begin
			if (rx_st && bit_reg < 4'h8) begin
				sh_next = {sh_reg[6:0], sda_s};
				bit_next = bit_reg + 4'h1;
			end else if (tx_st && bit_reg == 4'h8) begin
				// a not-acknowledge from the master ends the read
				st_next = sda_s ? cfo_pkg::SM_IDLE : st_reg;
				bit_next = sda_s ? 4'h0 : 4'h9;
			end
		end else if (scl_fall) begin
			if (rx_st && bit_reg == 4'h8) begin
				bit_next = 4'h9;
				drv_next = 1'b1;
				if (st_reg == cfo_pkg::SM_ADDR) begin
					drv_next = addr_hit;
					rd_next = sh_reg[0];
					if (!addr_hit)
						st_next = cfo_pkg::SM_IDLE;
				end else if (st_reg == cfo_pkg::SM_CMD) begin
					blk_next = ~sh_reg[cfo_pkg::CMD_BYTE_BIT];
					ptr_next = sh_reg[6:0];
				end else if (st_reg == cfo_pkg::SM_WDATA) begin
					wr_go = 1'b1;
					ptr_next = ptr_inc;
				end
			end else if (rx_st && bit_reg == 4'h9) begin
				drv_next = 1'b0;
				bit_next = 4'h0;
				if (st_reg == cfo_pkg::SM_ADDR && rd_reg) begin
					st_next = blk_reg ? cfo_pkg::SM_RCNT : cfo_pkg::SM_RDATA;
					sh_next = first_tx;
					drv_next = ~first_tx[7];
				end else if (st_reg == cfo_pkg::SM_ADDR) begin
					st_next = cfo_pkg::SM_CMD;
				end else if (st_reg == cfo_pkg::SM_CMD) begin
					st_next = blk_reg ? cfo_pkg::SM_WCNT : cfo_pkg::SM_WDATA;
				end else begin
					st_next = cfo_pkg::SM_WDATA;
				end
			end else if (tx_st && bit_reg < 4'h7) begin
				bit_next = bit_reg + 4'h1;
				sh_next = {sh_reg[6:0], 1'b0};
				drv_next = ~sh_reg[6];
			end else if (tx_st && bit_reg == 4'h7) begin
				bit_next = 4'h8;
				drv_next = 1'b0;
			end else if (tx_st && bit_reg == 4'h9) begin
				bit_next = 4'h0;
				st_next = cfo_pkg::SM_RDATA;
				sh_next = (st_reg == cfo_pkg::SM_RDATA) ? rd_inc : rd_cur;
				drv_next = (st_reg == cfo_pkg::SM_RDATA) ? ~rd_inc[7] : ~rd_cur[7];
				if (st_reg == cfo_pkg::SM_RDATA)
					ptr_next = ptr_inc;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_reg      <= cfo_pkg::SM_IDLE;
			bit_reg     <= 4'h0;
			sh_reg      <= 8'h00;
			ptr_reg     <= 7'h00;
			drv_reg     <= 1'b0;
			blk_reg     <= 1'b0;
			rd_reg      <= 1'b0;
			sda_out_reg <= 1'b0;
		end else if (ce) begin
			st_reg  <= st_next;
			bit_reg <= bit_next;
			sh_reg  <= sh_next;
			ptr_reg <= ptr_next;
			drv_reg <= drv_next;
			blk_reg <= blk_next;
			rd_reg  <= rd_next;
		end
	end

	// ****************************************
	// output channels
	// ****************************************
	wire [7:0] en_bits = {en_b_reg[cfo_pkg::EN_B_CH7], en_b_reg[cfo_pkg::EN_B_CH6],
		en_a_reg[cfo_pkg::EN_A_CH5], en_a_reg[cfo_pkg::EN_A_CH4],
		en_a_reg[cfo_pkg::EN_A_CH3], en_a_reg[cfo_pkg::EN_A_CH2],
		en_a_reg[cfo_pkg::EN_A_CH1], en_a_reg[cfo_pkg::EN_A_CH0]};
	wire [7:0] ch_run = {cfo_pkg::NUM_CH{pgood_reg & pd_n_reg}} & en_bits & ~oe_n_s;
	wire       park_tri = pgood_reg & output_setting_reg[cfo_pkg::OUTPUT_SETTING_PARK];

	for (genvar i = 0; i < cfo_pkg::NUM_CH; i++) begin : g_ch
		cfo_chan u_chan (
			.clk_sys  (clk_sys),
			.nrst     (nrst),
			.ce       (ce),
			.run      (ch_run[i]),
			.park_tri (park_tri),
			.ref_lvl  (ref_s),
			.leg_p    (buffered_clock_outputs_p[i]),
			.leg_n    (buffered_clock_outputs_n[i]),
			.leg_oe   (buffered_clock_outputs_oe[i])
		);
	end

	assign smb_data_out           = sda_out_reg;
	assign smb_data_oe            = drv_reg;
	assign termination_select_bit = output_setting_reg[cfo_pkg::OUTPUT_SETTING_TERM];
	assign slew_trim_lo           = slew_reg[3:0];
	assign slew_trim_hi           = slew_reg[7:4];
	assign power_good_state       = pgood_reg;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	pg_set_a: assert property ((ce && pg_rise && !pgood_reg) |=> pgood_reg)
		else $error("power-good not set on first rise");
	pg_hold_a: assert property (pgood_reg |=> pgood_reg)
		else $error("power-good cleared without power loss");
	addr_lock_a: assert property ((pgood_reg && $past(pgood_reg)) |-> $stable(sel_reg))
		else $error("address select changed after capture");
	addr_ll_a: assert property ((sel_reg == 4'h0) |-> (addr_w == 8'hD8))
		else $error("wrong slave address for low/low");
	pd_entry_a: assert property ($fell(pd_n_reg) |-> ($past(pd_cnt_reg) == 2'h2)
		&& !$past(pg_s) && $past(ref_rise))
		else $error("power-down entered without three reference edges");
	bus_float_a: assert property ((ce && !pg_s) |=> !smb_data_oe)
		else $error("data line driven while pin low");
	bus_freeze_a: assert property ((ce && !bus_on) |=>
		($stable(en_a_reg) && $stable(en_b_reg)
		&& $stable(output_setting_reg) && $stable(slew_reg)))
		else $error("register changed while bus inactive");
	pre_pg_low_a: assert property ((ce && !pgood_reg) |=>
		(buffered_clock_outputs_oe == 8'hFF
		&& buffered_clock_outputs_p == 8'h00 && buffered_clock_outputs_n == 8'h00))
		else $error("output not low before power-good");
	ch5_cause_a: assert property (($past(ce) && buffered_clock_outputs_p[5]) |->
		($past(en_a_reg[7]) && !$past(oe_n_s[5]) && $past(pd_n_reg)))
		else $error("channel 5 ran without its own enables");
	pd_stop_a: assert property ((ce && pgood_reg && !pd_n_reg) |=> (buffered_clock_outputs_p == 8'h00))
		else $error("output ran during power-down");

	pg_cov: cover property (ce && pg_rise && !pgood_reg);
	pd_cov: cover property ($fell(pd_n_reg));
	wr_cov: cover property (wr_en_a);
	rd_cov: cover property (st_reg == cfo_pkg::SM_RDATA && scl_rise && bit_reg == 4'h8 && !sda_s);
endmodule
`default_nettype wire

// ---- verif/cfo_host_model.sv ----
// smbus host and power sequencing model facing the fanout control block
// assumes the bench resolves the pulled-up data wire and feeds it back
`timescale 1ns/100ps
`default_nettype none
module cfo_host_model (
	input  wire logic clk_sys,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda,
	output logic      ref_clk,
	output logic      pg_pin
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		ref_clk = 1'b0;
		pg_pin = 1'b0;
	end

	// ****************************************
	// reference clock and power pin
	// ****************************************
	// free running, so it is present before power-up and through power-down entry;
	// half period of four system clocks gives the 320 ns reference
	logic [1:0] ref_div = 2'h0;

	always @(posedge clk_sys) begin
		ref_div <= ref_div + 2'h1;
		if (ref_div == 2'h3) begin
			ref_clk <= ~ref_clk;
		end
	end

	task automatic power(input logic v);
		pg_pin <= v;
	endtask

	// ****************************************
	// bus cycles, 8 system clocks per bit
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	// data moves only mid-low; the line is read late in the high phase
	task automatic bit_x(input logic b, output logic r);
		scl <= 1'b0;
		tick(2);
		sda <= b;
		tick(2);
		scl <= 1'b1;
		tick(3);
		r = sda_line;
		tick(1);
	endtask

	// start is cond(1,0), stop is cond(0,1)
	task automatic cond(input logic first, input logic last);
		scl <= 1'b0;
		tick(2);
		sda <= first;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda <= last;
		tick(4);
	endtask

	task automatic byte_x(input logic [7:0] d, input logic a_in,
			output logic [7:0] r, output logic a_out);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r[i]);
		end
		bit_x(a_in, a_out);
	endtask

	// callers address only the mapped registers
	task automatic wr(input logic [7:0] adr, input logic [7:0] cmd,
			input logic [23:0] dat, input int n, output logic ok);
		logic [7:0] r;
		logic       a;
		cond(1'b1, 1'b0);
		byte_x(adr, 1'b1, r, a);
		ok = ~a;
		byte_x(cmd, 1'b1, r, a);
		ok &= ~a;
		for (int k = 0; k < n; k++) begin
			byte_x(dat[8*k+:8], 1'b1, r, a);
			ok &= ~a;
		end
		cond(1'b0, 1'b1);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [7:0] cmd, input int n,
			output logic [15:0] q, output logic ok);
		logic [7:0] r;
		logic       a;
		q = 16'h0000;
		cond(1'b1, 1'b0);
		byte_x(adr, 1'b1, r, a);
		ok = ~a;
		byte_x(cmd, 1'b1, r, a);
		ok &= ~a;
		cond(1'b1, 1'b0);
		byte_x(adr | 8'h01, 1'b1, r, a);
		ok &= ~a;
		for (int k = 0; k < n; k++) begin
			byte_x(8'hFF, k == n - 1, r, a);
			q[8*k+:8] = r;
		end
		cond(1'b0, 1'b1);
	endtask
endmodule
`default_nettype wire

// ---- verif/cfo_top_tb.sv ----
// self-checking bench for the fanout output control block
// assumes the host model owns the bus, reference clock and power pin
`timescale 1ns/100ps
`default_nettype none
module cfo_top_tb;
	localparam logic [7:0] REV_V  = 8'h29; // arbitrary value
	localparam logic [7:0] PART_V = 8'h91; // arbitrary value
	logic       clk_sys  = 1'b0;
	logic       nrst     = 1'b0;
	logic       ce       = 1'b1;
	logic       sda_o;
	logic [7:0] pins     = 8'hFF;
	logic [1:0] sel0     = 2'h0;
	logic [1:0] sel1     = 2'h0;
	logic [7:0] adr      = 8'hD8;
	logic [7:0] ck_p;
	logic [7:0] ck_n;
	logic [7:0] ck_oe;
	logic [3:0] slew_lo;
	logic [3:0] slew_hi;
	logic       term;
	logic       pgood;
	logic       sda_oe;
	wire        scl;
	wire        sda;
	wire        ref_clk;
	wire        pg_pin;
	wire        sda_line = sda & ~sda_oe;
	int         n_errors = 0;
	int         n_tests  = 0;

	always #20 clk_sys = ~clk_sys;

	cfo_host_model host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda(sda),
		.ref_clk(ref_clk), .pg_pin(pg_pin));

	cfo_top #(.REV_VENDOR_ID(REV_V), .PART_ID(PART_V)) dut (
		.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .input_reference_clock(ref_clk),
		.power_good_powerdown_pin(pg_pin), .hw_output_enable_pin_n(pins),
		.addr_select_pin_0(sel0), .addr_select_pin_1(sel1), .smb_clk_in(scl),
		.smb_data_in(sda_line), .smb_data_out(sda_o), .smb_data_oe(sda_oe),
		.buffered_clock_outputs_p(ck_p), .buffered_clock_outputs_n(ck_n),
		.buffered_clock_outputs_oe(ck_oe), .termination_select_bit(term),
		.slew_trim_lo(slew_lo), .slew_trim_hi(slew_hi), .power_good_state(pgood));

	// ****************************************
	// shared helpers
	// ****************************************
	task automatic check(input logic [15:0] seen, input logic [15:0] ev, input string what);
		n_tests++;
		if (seen !== ev) begin
			n_errors++;
			$display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, ev);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic do_reset;
		nrst <= 1'b0;
		host.power(1'b0);
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (2) @(posedge clk_sys);
	endtask

	// channels whose positive leg moved during eight clocks, one reference period
	task automatic act(output logic [7:0] m);
		logic [7:0] p0;
		@(posedge clk_sys);
		p0 = ck_p;
		m = 8'h00;
		repeat (8) begin
			@(posedge clk_sys);
			m |= ck_p ^ p0;
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_before_pg;
		logic ok;
		pins <= 8'h00;
		repeat (6) @(posedge clk_sys);
		check({ck_p, ck_n}, 16'h0000, "legs before power-good");
		check({7'h0, term, slew_hi, slew_lo}, 16'h0066, "setting reset");
		host.wr(adr, 8'h88, 24'h0, 1, ok);
		check(16'(ok), 16'h0, "ack with pin low");
		check(16'(pgood), 16'h0, "power-good idle");
		$display("test before power-good done");
	endtask

	task automatic t_addr;
		logic [7:0] at [9] = '{8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6, 8'hCA, 8'hCC, 8'hCE};
		logic       ok;
		for (int i = 0; i < 9; i++) begin
			do_reset();
			sel1 <= 2'(i / 3);
			sel0 <= 2'(i % 3);
			repeat (4) @(posedge clk_sys);
			host.power(1'b1);
			repeat (8) @(posedge clk_sys);
			check(16'(pgood), 16'h1, "power-good set");
			sel0 <= 2'((i + 1) % 3);
			host.wr(at[i], 8'h88, 24'h0, 1, ok);
			check(16'(ok), 16'h1, "own address");
			host.wr(at[(i + 1) % 9], 8'h88, 24'h0, 1, ok);
			check(16'(ok), 16'h0, "foreign address");
		end
		$display("test addresses done");
	endtask

	task automatic t_regs;
		logic [6:0]  ix [11] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h07,
			7'h08, 7'h4C, 7'h10};
		logic [7:0]  ev [11] = '{8'h47, 8'hFF, 8'h0F, 8'h5A, 8'h00, REV_V, PART_V, 8'h08,
			8'h00, 8'h66, 8'h00};
		logic [15:0] q;
		logic        ok;
		pins <= 8'h5A;
		host.wr(adr, 8'h83, 24'h0, 1, ok);
		for (int i = 0; i < 11; i++) begin
			host.rd(adr, {1'b1, ix[i]}, 1, q, ok);
			check(q, {8'h0, ev[i]}, "register value");
		end
		check(16'(sda_o), 16'h0, "data out level");
		host.wr(adr, 8'h88, 24'hFF, 1, ok);
		host.wr(adr, 8'hCC, 24'hA3, 1, ok);
		host.rd(adr, 8'h88, 1, q, ok);
		check(q, 16'h003F, "output setting");
		check({7'h0, term, slew_hi, slew_lo}, 16'h01A3, "termination and slew");
		host.wr(adr, 8'h88, 24'h0, 1, ok);
		$display("test registers done");
	endtask

	task automatic t_enable;
		logic [15:0] e [8] = '{16'h0002, 16'h0004, 16'h0010, 16'h0020, 16'h0040, 16'h0080,
			16'h0100, 16'h0400};
		logic [15:0] q;
		logic [7:0]  m;
		logic        ok;
		pins <= 8'h00;
		for (int c = 0; c < 8; c++) begin
			host.wr(adr, 8'h01, {e[c], 8'h02}, 3, ok);
			host.rd(adr, 8'h01, 2, q, ok);
			check(q, {e[c][7:0], 8'h08}, "block read");
			act(m);
			check({8'h0, m}, 16'h1 << c, "lone channel");
			check({ck_n & m, ck_oe}, {~ck_p & m, 8'hFF}, "legs");
			pins <= 8'h1 << c;
			repeat (5) @(posedge clk_sys);
			act(m);
			check({m, ck_p | ck_n}, 16'h0, "pin high stops");
			pins <= 8'h00;
		end
		$display("test enables done");
	endtask

	task automatic t_pdown;
		logic [15:0] q;
		logic [7:0]  m;
		logic        ok;
		host.wr(adr, 8'h01, 24'h0FFF02, 3, ok);
		host.wr(adr, 8'h88, 24'h10, 1, ok);
		host.power(1'b0);
		// three reference rises take up to 24 clocks after the synchronised fall
		repeat (40) @(posedge clk_sys);
		check({ck_oe, 7'h0, pgood}, 16'h0001, "parked floating");
		host.wr(adr, 8'h88, 24'h0, 1, ok);
		check(16'(ok), 16'h0, "no ack in power-down");
		host.power(1'b1);
		repeat (8) @(posedge clk_sys);
		act(m);
		check({8'h0, m}, 16'h00FF, "all run again");
		ce <= 1'b0;
		repeat (2) @(posedge clk_sys);
		act(m);
		check({8'h0, m}, 16'h0000, "clock enable freezes legs");
		ce <= 1'b1;
		host.rd(adr, 8'h88, 1, q, ok);
		check(q, 16'h0010, "register kept");
		host.wr(adr, 8'h88, 24'h0, 1, ok);
		host.power(1'b0);
		repeat (40) @(posedge clk_sys);
		check({ck_oe, ck_p | ck_n}, 16'hFF00, "parked low");
		host.power(1'b1);
		$display("test power-down done");
	endtask

	initial begin
		repeat (10) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		t_before_pg();
		t_addr();
		adr = 8'hCE;
		t_regs();
		t_enable();
		t_pdown();
		summarize();
	end

	// the whole run needs about 17600 clocks
	initial begin
		#2000000;
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		summarize();
	end
endmodule
`default_nettype wire
